// ---- src/qrt_timer_block.v ----
`include "qrt_regs.vh"
`default_nettype none

// ==========================================================
// Quad reload timer with event input and pulse output
module qrt_timer_block #(
    parameter PRSW = 3
) (
    input  wire            ref_clk,
    input  wire            resetn,
    input  wire [15:0]     ioAddr,
    input  wire            ioWrEn,
    input  wire            ioRdEn,
    input  wire [3:0]      ioWrData,
    output reg  [3:0]      ioRdData_r,
    input  wire [PRSW-1:0] prescalerSetting,
    input  wire            eventInputPin,
    output wire [3:0]      irqReq,
    output wire            pulseOutputPin
);
    localparam HW = PRSW + 9;

    // ==========================================================
    // Divider tick decode, shared by all four timers
    function selTick;
        input [1:0] sel;
        input [7:0] cnt;
        begin
            case (sel)
                2'd0:    selTick = 1'b1;
                2'd1:    selTick = (cnt[1:0] == `QRT_DIV4_END);
                2'd2:    selTick = (cnt[4:0] == `QRT_DIV32_END);
                2'd3:    selTick = (cnt == `QRT_DIV256_END);
                default: selTick = 1'b0;
            endcase
        end
    endfunction

    // ==========================================================
    // Registers
    reg  [1:0]      widthMode_r;
    reg             eventCountMode_r;
    reg             noiseRejectSelect_r;
    reg             eventEdgePolarity_r;
    reg             pulseOutputEn_r;
    reg  [1:0]      pulseChannelSelect_r;
    reg  [7:0]      clockDivideSelect_r;
    reg  [3:0]      run_r;
    reg  [31:0]     reloadValue_r;
    reg  [3:0]      underflowIrqMask_r;
    reg  [3:0]      underflowIrqFlag_r;
    reg             pulseOutput_r;
    reg  [7:0]      divCnt_r;
    reg  [PRSW+7:0] nrCnt_r;
    reg  [3:0]      rdNxt;

    wire [31:0]     count;
    wire [31:0]     bufView;
    wire [3:0]      underflow;
    wire [3:0]      countTick;
    wire [3:0]      preset;
    wire [3:0]      irqEvent;
    wire            nrTick;
    wire            eventEdge;
    wire [PRSW+7:0] nrLimit;

    wire            isCtl  = ({ioAddr[15:2], 2'b00} == `QRT_ADDR_CTL);
    wire            isRld  = ({ioAddr[15:3], 3'b000} == `QRT_ADDR_RLD);
    wire            isData = ({ioAddr[15:3], 3'b000} == `QRT_ADDR_DATA);
    wire [1:0]      ctlIdx = ioAddr[1:0];
    wire [1:0]      dataIdx = ioAddr[2:1];
    wire            dataRd = ioRdEn & isData;
    wire            wrCtl  = ioWrEn & isCtl;
    // High-order control of a wide pair ignores writes
    wire            ctlBlocked = ctlIdx[0] & widthMode_r[ctlIdx[1]];

    // ==========================================================
    // Free divider and rejector clock
    assign nrLimit = {prescalerSetting, `QRT_NR_LOW};
    assign nrTick  = (nrCnt_r == nrLimit);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_r <= `QRT_RST_BYTE;
            nrCnt_r  <= {(PRSW+8){1'b0}};
        end else begin
            divCnt_r <= divCnt_r + 8'h01;
            nrCnt_r  <= nrTick ? {(PRSW+8){1'b0}} : nrCnt_r + {{(PRSW+7){1'b0}}, 1'b1};
        end
    end

    // ==========================================================
    // Register writes
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            widthMode_r          <= 2'b00;
            eventCountMode_r     <= `QRT_RST_BIT;
            noiseRejectSelect_r  <= `QRT_RST_BIT;
            eventEdgePolarity_r  <= `QRT_RST_BIT;
            pulseOutputEn_r      <= `QRT_RST_BIT;
            pulseChannelSelect_r <= 2'b00;
            clockDivideSelect_r  <= `QRT_RST_BYTE;
            run_r                <= `QRT_RST_NIBBLE;
            reloadValue_r        <= 32'h0000_0000;
            underflowIrqMask_r   <= `QRT_RST_NIBBLE;
        end else if (ioWrEn) begin
            if (ioAddr == `QRT_ADDR_MODE) begin
                widthMode_r <= ioWrData[1:0];
            end
            if (ioAddr == `QRT_ADDR_EVT) begin
                eventCountMode_r    <= ioWrData[`QRT_EVT_MODE];
                noiseRejectSelect_r <= ioWrData[`QRT_EVT_NR];
                eventEdgePolarity_r <= ioWrData[`QRT_EVT_POL];
            end
            if (ioAddr == `QRT_ADDR_PULSE) begin
                pulseOutputEn_r      <= ioWrData[`QRT_PULSE_EN];
                pulseChannelSelect_r <= ioWrData[1:0];
            end
            if (isCtl && !ctlBlocked) begin
                clockDivideSelect_r[{ctlIdx, 1'b0} +: 2] <= ioWrData[`QRT_CTL_DIV_LSB +: 2];
                run_r[ctlIdx]                            <= ioWrData[`QRT_CTL_RUN];
            end
            if (isRld) begin
                reloadValue_r[{ioAddr[2:0], 2'b00} +: 4] <= ioWrData;
            end
            if (ioAddr == `QRT_ADDR_MASK) begin
                underflowIrqMask_r <= ioWrData;
            end
        end
    end

    // ==========================================================
    // Count clocks; wide pairs run from the low-order controls
    assign countTick[0] = run_r[0] & (eventCountMode_r ? eventEdge
                                                       : selTick(clockDivideSelect_r[1:0], divCnt_r));
    assign countTick[1] = widthMode_r[0] ? underflow[0]
                                         : run_r[1] & selTick(clockDivideSelect_r[3:2], divCnt_r);
    assign countTick[2] = run_r[2] & selTick(clockDivideSelect_r[5:4], divCnt_r);
    assign countTick[3] = widthMode_r[1] ? underflow[2]
                                         : run_r[3] & selTick(clockDivideSelect_r[7:6], divCnt_r);

    assign preset[0] = wrCtl & (ctlIdx == 2'd0) & ioWrData[`QRT_CTL_PRESET];
    assign preset[1] = widthMode_r[0] ? preset[0] : wrCtl & (ctlIdx == 2'd1) & ioWrData[`QRT_CTL_PRESET];
    assign preset[2] = wrCtl & (ctlIdx == 2'd2) & ioWrData[`QRT_CTL_PRESET];
    assign preset[3] = widthMode_r[1] ? preset[2] : wrCtl & (ctlIdx == 2'd3) & ioWrData[`QRT_CTL_PRESET];

    qrt_event_input u_event (
        .ref_clk           (ref_clk),
        .resetn            (resetn),
        .eventInputPin     (eventInputPin),
        .nrTick            (nrTick),
        .noiseRejectSelect (noiseRejectSelect_r),
        .eventEdgePolarity (eventEdgePolarity_r),
        .countEdge         (eventEdge)
    );

    // ==========================================================
    // Counters and their read holds
    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1) begin : g_timer
            localparam       IS_HIGH = k % 2;
            localparam [1:0] LOW_IDX = k & 2;
            reg              holdOn_r;
            reg  [7:0]       holdBuf_r;
            reg  [HW-1:0]    holdCnt_r;
            wire             pairWide = widthMode_r[k / 2];
            wire [HW-1:0]    holdLimit = pairWide ? {prescalerSetting, `QRT_HOLD16_LOW}
                                                  : {1'b0, prescalerSetting, `QRT_HOLD8_LOW};
            wire             rdLow  = dataRd & (dataIdx == k) & ~ioAddr[0];
            wire             rdHigh = dataRd & (dataIdx == k) & ioAddr[0];
            wire             partnerLow = dataRd & (dataIdx == LOW_IDX) & ~ioAddr[0];
            wire             wideHigh = (IS_HIGH == 1) & pairWide;
            // Low read of a held wide high half must not re-latch
            wire             latch = (rdLow & ~(wideHigh & holdOn_r)) | (wideHigh & partnerLow);

            qrt_timer_core u_core (
                .ref_clk     (ref_clk),
                .resetn      (resetn),
                .countTick   (countTick[k]),
                .preset      (preset[k]),
                .reloadValue (reloadValue_r[8*k +: 8]),
                .count_r     (count[8*k +: 8]),
                .underflow   (underflow[k])
            );

            always @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    holdOn_r  <= `QRT_RST_BIT;
                    holdBuf_r <= `QRT_RST_BYTE;
                    holdCnt_r <= {HW{1'b0}};
                end else if (latch) begin
                    holdOn_r  <= 1'b1;
                    holdBuf_r <= count[8*k +: 8];
                    holdCnt_r <= {HW{1'b0}};
                end else if (rdHigh) begin
                    holdOn_r <= 1'b0;
                end else if (holdOn_r) begin
                    if (holdCnt_r == holdLimit) begin
                        holdOn_r <= 1'b0;
                    end else begin
                        holdCnt_r <= holdCnt_r + {{(HW-1){1'b0}}, 1'b1};
                    end
                end
            end

            assign bufView[8*k +: 8] = holdOn_r ? holdBuf_r : count[8*k +: 8];
            // Low half of a wide pair never flags
            assign irqEvent[k] = underflow[k] & ~((IS_HIGH == 0) & pairWide);
        end
    endgenerate

    // ==========================================================
    // Flags: underflow wins over a same-cycle clear
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            underflowIrqFlag_r <= `QRT_RST_NIBBLE;
        end else if (ioWrEn && ioAddr == `QRT_ADDR_FLAG) begin
            underflowIrqFlag_r <= (underflowIrqFlag_r & ~ioWrData) | irqEvent;
        end else begin
            underflowIrqFlag_r <= underflowIrqFlag_r | irqEvent;
        end
    end

    assign irqReq = underflowIrqFlag_r & underflowIrqMask_r;

    // ==========================================================
    // Pulse output
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pulseOutput_r <= `QRT_RST_BIT;
        end else if (underflow[pulseChannelSelect_r]) begin
            pulseOutput_r <= ~pulseOutput_r;
        end
    end

    // Ungated enable: switching may clip up to half a pulse cycle
    assign pulseOutputPin = pulseOutputEn_r ? pulseOutput_r : 1'b1;

    // ==========================================================
    // Read data, one cycle after the strobe
    always @* begin
        rdNxt = `QRT_RST_NIBBLE;
        if (ioAddr == `QRT_ADDR_MODE) begin
            rdNxt = {2'b00, widthMode_r};
        end else if (ioAddr == `QRT_ADDR_EVT) begin
            rdNxt = {1'b0, eventCountMode_r, noiseRejectSelect_r, eventEdgePolarity_r};
        end else if (ioAddr == `QRT_ADDR_PULSE) begin
            rdNxt = {1'b0, pulseOutputEn_r, pulseChannelSelect_r};
        end else if (isCtl) begin
            rdNxt = {clockDivideSelect_r[{ctlIdx, 1'b0} +: 2], 1'b0, run_r[ctlIdx]};
        end else if (isRld) begin
            rdNxt = reloadValue_r[{ioAddr[2:0], 2'b00} +: 4];
        end else if (isData) begin
            rdNxt = bufView[{ioAddr[2:0], 2'b00} +: 4];
        end else if (ioAddr == `QRT_ADDR_MASK) begin
            rdNxt = underflowIrqMask_r;
        end else if (ioAddr == `QRT_ADDR_FLAG) begin
            rdNxt = underflowIrqFlag_r;
        end
    end

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ioRdData_r <= `QRT_RST_NIBBLE;
        end else if (ioRdEn) begin
            ioRdData_r <= rdNxt;
        end
    end
endmodule // qrt_timer_block

`default_nettype wire

// ---- src/qrt_regs.vh ----
`ifndef QRT_REGS_VH
`define QRT_REGS_VH

// ==========================================================
// Register addresses
`define QRT_ADDR_MODE   16'hffc0
`define QRT_ADDR_EVT    16'hffc1
`define QRT_ADDR_PULSE  16'hffc2
`define QRT_ADDR_CTL    16'hffc4
`define QRT_ADDR_RLD    16'hffd0
`define QRT_ADDR_DATA   16'hffd8
`define QRT_ADDR_MASK   16'hffe2
`define QRT_ADDR_FLAG   16'hfff2

// ==========================================================
// Field positions
`define QRT_CTL_DIV_LSB 2
`define QRT_CTL_PRESET  1
`define QRT_CTL_RUN     0
`define QRT_EVT_MODE    2
`define QRT_EVT_NR      1
`define QRT_EVT_POL     0
`define QRT_PULSE_EN    2

// ==========================================================
// Reset values
`define QRT_RST_NIBBLE  4'h0
`define QRT_RST_BYTE    8'h00
`define QRT_RST_BIT     1'b0
`define QRT_EVT_IDLE    1'b1

// ==========================================================
// Timing: low bits of (256*n - 1) and (512*n - 1), divider ends
`define QRT_HOLD8_LOW   8'hff
`define QRT_HOLD16_LOW  9'h1ff
`define QRT_NR_LOW      8'hff
`define QRT_DIV4_END    2'h3
`define QRT_DIV32_END   5'h1f
`define QRT_DIV256_END  8'hff

`endif

// ---- src/qrt_timer_core.v ----
`include "qrt_regs.vh"
`default_nettype none

// ==========================================================
// Eight-bit reloadable down counter
module qrt_timer_core (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       countTick,
    input  wire       preset,
    input  wire [7:0] reloadValue,
    output reg  [7:0] count_r,
    output wire       underflow
);
    assign underflow = countTick & (count_r == `QRT_RST_BYTE);

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= `QRT_RST_BYTE;
        end else if (preset) begin
            count_r <= reloadValue;
        end else if (underflow) begin
            count_r <= reloadValue;
        end else if (countTick) begin
            count_r <= count_r - 8'h01;
        end
    end
endmodule // qrt_timer_core

`default_nettype wire

// ---- src/qrt_event_input.v ----
`include "qrt_regs.vh"
`default_nettype none

// ==========================================================
// Event pin conditioning for timer 0
module qrt_event_input (
    input  wire ref_clk,
    input  wire resetn,
    input  wire eventInputPin,
    input  wire nrTick,
    input  wire noiseRejectSelect,
    input  wire eventEdgePolarity,
    output wire countEdge
);
    reg  sync1_r;
    reg  sync2_r;
    reg  nrStage_r;
    reg  nrOut_r;
    reg  lvlPrev_r;
    wire lvl;

    // Two flops; only the second is looked at
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= `QRT_EVT_IDLE;
            sync2_r <= `QRT_EVT_IDLE;
        end else begin
            sync1_r <= eventInputPin;
            sync2_r <= sync1_r;
        end
    end

    // Level must agree on two rejector ticks in a row
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            nrStage_r <= `QRT_EVT_IDLE;
            nrOut_r   <= `QRT_EVT_IDLE;
        end else if (nrTick) begin
            nrStage_r <= sync2_r;
            if (nrStage_r == sync2_r) begin
                nrOut_r <= sync2_r;
            end
        end
    end

    assign lvl = noiseRejectSelect ? nrOut_r : sync2_r;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lvlPrev_r <= `QRT_EVT_IDLE;
        end else begin
            lvlPrev_r <= lvl;
        end
    end

    // Switching the filter can fake one edge; switching polarity cannot
    assign countEdge = eventEdgePolarity ? (lvl & ~lvlPrev_r) : (~lvl & lvlPrev_r);
endmodule // qrt_event_input

`default_nettype wire

// ---- tb/qrt_timer_block_monitor.sv ----
`include "qrt_regs.vh"
`default_nettype none
module qrt_timer_block_monitor #(
    parameter PRSW = 3
) (
    input wire logic            ref_clk,
    input wire logic            resetn,
    input wire logic [15:0]     ioAddr,
    input wire logic            ioWrEn,
    input wire logic            ioRdEn,
    input wire logic [3:0]      ioWrData,
    input wire logic [3:0]      ioRdData_r,
    input wire logic [PRSW-1:0] prescalerSetting,
    input wire logic            eventInputPin,
    input wire logic [3:0]      irqReq,
    input wire logic            pulseOutputPin
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // ==========================================================
    // Shadows of the width mode, mask and pulse enable bits
    logic [1:0] modeCopy_r;
    logic [3:0] maskCopy_r;
    logic       pulseEnCopy_r;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            modeCopy_r    <= 2'h0;
            maskCopy_r    <= 4'h0;
            pulseEnCopy_r <= 1'b0;
        end else if (ioWrEn) begin
            if (ioAddr == `QRT_ADDR_MODE) modeCopy_r <= ioWrData[1:0];
            if (ioAddr == `QRT_ADDR_MASK) maskCopy_r <= ioWrData;
            if (ioAddr == `QRT_ADDR_PULSE) pulseEnCopy_r <= ioWrData[`QRT_PULSE_EN];
        end
    end
    // ==========================================================
    // Assertions
    chk_pin_idle_high:
        assert property (!pulseEnCopy_r |-> pulseOutputPin) else $error("pulse pin low while disabled");
    chk_irq_masked:
        assert property ((irqReq & ~maskCopy_r) == 4'h0) else $error("request raised through a mask");
    chk_mode_read:
        assert property (ioRdEn && ioAddr == `QRT_ADDR_MODE |=> ioRdData_r == {2'b00, $past(modeCopy_r)})
        else $error("width mode readback wrong");
    chk_mask_read:
        assert property (ioRdEn && ioAddr == `QRT_ADDR_MASK |=> ioRdData_r == $past(maskCopy_r))
        else $error("mask readback wrong");
    chk_flag_read:
        assert property (ioRdEn && ioAddr == `QRT_ADDR_FLAG |=> (ioRdData_r & $past(maskCopy_r)) == $past(irqReq))
        else $error("flag readback disagrees with request");
    chk_read_stable:
        assert property (!ioRdEn |=> $stable(ioRdData_r)) else $error("read data moved without a read");
    chk_unmapped_zero:
        assert property (ioRdEn && ioAddr == 16'hffc3 |=> ioRdData_r == 4'h0) else $error("hole read not zero");
    chk_preset_zero:
        assert property (ioRdEn && ioAddr[15:2] == 14'h3ff1 |=> !ioRdData_r[1]) else $error("preset bit read as one");
    // Mode may have just changed, so two cycles of 16-bit history are required
    chk_low_flag_quiet:
        assert property ($rose(irqReq[0]) |-> !$past(modeCopy_r[0]) || !$past(modeCopy_r[0], 2)
            || $past(ioWrEn && ioAddr == `QRT_ADDR_MASK)) else $error("low timer flag set in 16-bit mode");
    cov_pulse_fell: cover property ($fell(pulseOutputPin));
    cov_high_irq: cover property ($rose(irqReq[1]));
    cov_data_read: cover property (ioRdEn && ioAddr == `QRT_ADDR_DATA);
endmodule // qrt_timer_block_monitor

bind qrt_timer_block qrt_timer_block_monitor #(.PRSW(PRSW)) qrt_timer_block_monitor_i (
    .ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
    .ioWrData(ioWrData), .ioRdData_r(ioRdData_r), .prescalerSetting(prescalerSetting),
    .eventInputPin(eventInputPin), .irqReq(irqReq), .pulseOutputPin(pulseOutputPin));
`default_nettype wire

// ---- tb/qrt_event_source.sv ----
`default_nettype none
module qrt_event_source (
    input  wire logic ref_clk,
    output var  logic eventInputPin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial eventInputPin = 1'b1;
    // ==========================================================
    // Level held for wid cycles; always driven, no floating pin
    task automatic drive(input logic lvl, input int wid);
        @(negedge ref_clk);
        eventInputPin = lvl;
        repeat (wid) @(negedge ref_clk);
    endtask
endmodule // qrt_event_source
`default_nettype wire

// ---- tb/qrt_timer_block_bench.sv ----
`include "qrt_regs.vh"
`default_nettype none
module qrt_timer_block_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [15:0] ioAddr = 16'h0000;
    logic        ioWrEn = 1'b0;
    logic        ioRdEn = 1'b0;
    logic [3:0]  ioWrData = 4'h0;
    logic [2:0]  prescaler_setting = 3'h0;
    logic [3:0]  ioRdData_r;
    logic [3:0]  irqReq;
    logic        pulseOutputPin;
    wire         eventInputPin;
    logic        rdTaken_r = 1'b0;
    logic [3:0]  expQ[$];
    logic [3:0]  careQ[$];
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          seed = 32'h0000_3e78;
    int          gap;
    int          wid;
    logic [7:0]  rl;
    logic [7:0]  rh;
    always #2 ref_clk = ~ref_clk;
    qrt_timer_block #(.PRSW(3)) qrt_timer_block_i (
        .ref_clk(ref_clk), .resetn(resetn), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioRdEn(ioRdEn),
        .ioWrData(ioWrData), .ioRdData_r(ioRdData_r), .prescalerSetting(prescaler_setting),
        .eventInputPin(eventInputPin), .irqReq(irqReq), .pulseOutputPin(pulseOutputPin));
    qrt_event_source qrt_event_source_i (.ref_clk(ref_clk), .eventInputPin(eventInputPin));
    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(negedge ref_clk);
        ioAddr = a;
        ioWrData = d;
        ioWrEn = 1'b1;
        @(negedge ref_clk);
        ioWrEn = 1'b0;
    endtask
    // Reads have side effects, so the note is queued with the request
    task automatic rd(input logic [15:0] a, input logic [3:0] e, input logic [3:0] c = 4'hf);
        @(negedge ref_clk);
        ioAddr = a;
        ioRdEn = 1'b1;
        expQ.push_back(e & c);
        careQ.push_back(c);
        @(negedge ref_clk);
        ioRdEn = 1'b0;
    endtask
    task automatic wait_pin(output int cyc);
        logic p;
        p = pulseOutputPin;
        cyc = 0;
        while (pulseOutputPin === p && cyc < 20000) begin
            @(negedge ref_clk);
            cyc++;
        end
        if (cyc >= 20000) begin
            n_mismatch++;
            $display("[FAIL] pulse pin expected toggle seen none");
            stop_test();
        end
    endtask
    // ==========================================================
    // Read data watcher
    always @(posedge ref_clk) rdTaken_r <= ioRdEn;
    always @(negedge ref_clk) begin
        if (rdTaken_r && careQ.size() > 0) begin
            check("read nibble", 16'(ioRdData_r & careQ[0]), 16'(expQ[0]));
            void'(expQ.pop_front());
            void'(careQ.pop_front());
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (3) @(negedge ref_clk);
        resetn = 1'b1;
        check("pin after reset", 16'(pulseOutputPin), 16'h0001);
        check("irq after reset", 16'(irqReq), 16'h0000);
        rd(`QRT_ADDR_MODE, 4'h0);
        rd(`QRT_ADDR_EVT, 4'h0);
        rd(`QRT_ADDR_FLAG, 4'h0);
        rd(16'hffc3, 4'h0);
        wr(`QRT_ADDR_MODE, 4'hf);
        rd(`QRT_ADDR_MODE, 4'h3);
        wr(`QRT_ADDR_MODE, 4'h0);
        $display("test reset_regs done");
        for (int k = 0; k < 4; k++) begin
            rl = 8'(1 + ($random(seed) & 7));
            wr(16'(`QRT_ADDR_RLD + 2 * k), rl[3:0]);
            wr(16'(`QRT_ADDR_RLD + 2 * k + 1), rl[7:4]);
            wr(16'(`QRT_ADDR_CTL + k), {k[1:0], 2'b11});
            wr(`QRT_ADDR_PULSE, {2'b01, k[1:0]});
            wait_pin(gap);
            wait_pin(gap);
            check("pulse half period", 16'(gap), 16'((rl + 1) << ((k == 0) ? 0 : 3 * k - 1)));
            wr(16'(`QRT_ADDR_CTL + k), 4'h0);
        end
        wr(`QRT_ADDR_PULSE, 4'h0);
        check("pin disabled", 16'(pulseOutputPin), 16'h0001);
        $display("test pulse_channels done");
        rd(`QRT_ADDR_FLAG, 4'hf);
        wr(`QRT_ADDR_MASK, 4'h5);
        check("masked irq", 16'(irqReq), 16'h0005);
        wr(`QRT_ADDR_FLAG, 4'h1);
        rd(`QRT_ADDR_FLAG, 4'he);
        wr(`QRT_ADDR_FLAG, 4'hf);
        $display("test irq_mask done");
        for (int m = 0; m < 2; m++) begin
            prescaler_setting = 3'(m);
            wr(`QRT_ADDR_MODE, 4'(m));
            for (int late = 0; late < 2; late++) begin
                wr(`QRT_ADDR_RLD, 4'ha);
                wr(16'(`QRT_ADDR_RLD + 1), 4'h5);
                wr(`QRT_ADDR_CTL, 4'h2);
                rd(`QRT_ADDR_DATA, 4'ha);
                wr(16'(`QRT_ADDR_RLD + 1), 4'h3);
                wr(`QRT_ADDR_CTL, 4'h2);
                repeat (((200 + 100 * late) << m) * (m + 1)) @(negedge ref_clk);
                rd(16'(`QRT_ADDR_DATA + 1), late ? 4'h3 : 4'h5);
            end
        end
        prescaler_setting = 3'h0;
        // Rejector divider may wrap once when the setting shrinks
        repeat (2304) @(negedge ref_clk);
        $display("test count_hold done");
        rl = 8'(1 + ($random(seed) & 7));
        rh = 8'(1 + ($random(seed) & 3));
        wr(`QRT_ADDR_MODE, 4'h1);
        wr(`QRT_ADDR_RLD, rl[3:0]);
        wr(16'(`QRT_ADDR_RLD + 1), 4'h0);
        wr(16'(`QRT_ADDR_RLD + 2), rh[3:0]);
        wr(16'(`QRT_ADDR_RLD + 3), 4'h0);
        wr(`QRT_ADDR_CTL, 4'h3);
        wr(`QRT_ADDR_PULSE, 4'h5);
        wr(`QRT_ADDR_FLAG, 4'hf);
        wait_pin(gap);
        wait_pin(gap);
        check("cascade half period", 16'(gap), 16'((rl + 1) * (rh + 1)));
        rd(`QRT_ADDR_FLAG, 4'h2);
        wr(`QRT_ADDR_CTL, 4'h0);
        wr(`QRT_ADDR_MODE, 4'h0);
        $display("test cascade done");
        for (int c = 0; c < 4; c++) begin
            wid = c[1] ? 600 : 6;
            qrt_event_source_i.drive(~c[0], wid * 2);
            wr(`QRT_ADDR_EVT, {2'b01, c[1], c[0]});
            qrt_event_source_i.drive(~c[0], wid * 2);
            wr(`QRT_ADDR_RLD, 4'h3);
            wr(16'(`QRT_ADDR_RLD + 1), 4'h0);
            wr(`QRT_ADDR_CTL, 4'hf);
            wr(`QRT_ADDR_FLAG, 4'hf);
            repeat (3) begin
                qrt_event_source_i.drive(c[0], wid);
                qrt_event_source_i.drive(~c[0], wid);
            end
            if (c[1]) begin
                qrt_event_source_i.drive(c[0], 100);
                qrt_event_source_i.drive(~c[0], wid);
            end
            rd(`QRT_ADDR_FLAG, 4'h0, 4'h1);
            qrt_event_source_i.drive(c[0], wid * 2);
            rd(`QRT_ADDR_FLAG, 4'h1, 4'h1);
        end
        wr(`QRT_ADDR_CTL, 4'h0);
        wr(`QRT_ADDR_EVT, 4'h0);
        $display("test event_count done");
        repeat (2) @(negedge ref_clk);
        stop_test();
    end
endmodule // qrt_timer_block_bench
`default_nettype wire
